// ===== shared/cwd_map.vh
// Purpose: offsets, field positions and codes of the configuration word decoder
// Assumes: byte-addressed register port, 32-bit words
// Notes: definitions only
`ifndef CWD_MAP_VH
`define CWD_MAP_VH
// =====================================================================
// register offsets (byte addresses)
`define CWD_DEBUG_WORD_OFS 8'h00
`define CWD_POWER_WORD_OFS 8'h04
`define CWD_WDOG_WORD_OFS 8'h08
`define CWD_STATUS_OFS 8'h0C
`define CWD_RUNTIME_OFS 8'h10
`define CWD_ADDR_W 8
// =====================================================================
// field positions
`define CWD_DBG_CH_HI 4
`define CWD_DBG_CH_LO 3
`define CWD_DBG_SCAN_BIT 2
`define CWD_POR_LPBOR_BIT 3
`define CWD_POR_RETDIS_BIT 2
`define CWD_POR_BOR_HI 1
`define CWD_POR_BOR_LO 0
`define CWD_WDT_EN_BIT 15
`define CWD_WDT_CLK_HI 14
`define CWD_WDT_CLK_LO 13
`define CWD_WDT_RPS_HI 12
`define CWD_WDT_RPS_LO 8
`define CWD_WDT_WINDOW_MODE_DISABLE_BIT 7
`define CWD_WDT_WSZ_HI 6
`define CWD_WDT_WSZ_LO 5
`define CWD_WDT_SPS_HI 4
`define CWD_WDT_SPS_LO 0
// runtime register bits
`define CWD_RT_SBOR_BIT 0
`define CWD_RT_RETENTION_RUNTIME_ENABLE_BIT 1
`define CWD_RT_SLEEP_BIT 2
// =====================================================================
// codes
`define CWD_BOR_ALWAYS 2'h3
`define CWD_BOR_RUN_ONLY 2'h2
`define CWD_BOR_SOFT 2'h1
`define CWD_BOR_OFF 2'h0
`define CWD_CLK_LOW_POWER_RC_OSCILLATOR 2'h3
`define CWD_CLK_FAST 2'h2
`define CWD_CLK_RSVD 2'h1
`define CWD_CLK_SYS 2'h0
`define CWD_PS_MAX 5'h14
`define CWD_WORD_RESET 32'hFFFFFFFF
`endif

// ===== hdl/cwd_postscale.v
// Purpose: turn a five-bit postscale code into a one-hot divide ratio
// Assumes: ratio = 2**code, codes at or above 10100 saturate at 2**20
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "cwd_map.vh"
module cwd_postscale (
    input wire [4:0] i_code,
    output wire [20:0] o_ratio_onehot
);
    // =================================================================
    // decode
    wire [4:0] code_sat;
    assign code_sat = (i_code >= `CWD_PS_MAX) ? `CWD_PS_MAX : i_code;
    genvar g;
    generate
        for (g = 0; g < 21; g = g + 1) begin : g_bit
            // widen the code rather than cut the loop index
            assign o_ratio_onehot[g] = ({27'h0000000, code_sat} == g);
        end
    endgenerate
endmodule // cwd_postscale
`default_nettype wire

// ===== hdl/cwd_decoder.v
// Purpose: capture the three configuration words and decode static controls
// Assumes: words arrive on plain inputs, steady while reset is high
// Notes: words are read back over a simple register port
// Operation
// - debug channel 11/10/01 picks pin pair one/two/three, 00 none
// - debug word bit 2 enables the boundary-scan port
// - power word bit 3 enables low-power brown-out while main one off
// - power word bit 2 clear enables retention regulator, runtime-gated in sleep
// - brown-out field 11 keeps reset always on, software bit ignored
// - field 10 enables reset only while running, software bit ignored
// - field 01 follows software bit; 00 disables regardless
// - watchdog word bit 15 enables the watchdog
// - run clock field 11 low-power RC, 10 fast RC, 00 system, 01 reserved
// - run postscale ratio is two to the code, saturating at 2**20
// - sleep postscale uses the same encoding, saturating at 2**20
// - bit 7 set disables windowed mode, clear enables it
// - window field 11/10/01/00 gives 25/37.5/50/75 percent
// - in sleep the watchdog always runs from the low-power RC
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cwd_map.vh"
module cwd_decoder (
    input wire I_REF_CLK,
    input wire I_RST,
    input wire [31:0] i_debug_word,
    input wire [31:0] i_power_word,
    input wire [31:0] i_wdog_word,
    input wire i_sleep,
    input wire [7:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    output reg o_loaded,
    output reg o_debug_pin_pair_one,
    output reg o_debug_pin_pair_two,
    output reg o_debug_pin_pair_three,
    output reg o_scan_port_enable,
    output reg o_low_power_brownout_enable,
    output reg o_retention_regulator_on,
    output reg o_brownout_reset_enable,
    output reg o_watchdog_enable,
    output reg [1:0] o_watchdog_clock_select,
    output reg o_watchdog_clock_reserved,
    output reg [20:0] o_watchdog_ratio_onehot,
    output reg o_window_enable,
    output reg [3:0] o_window_eighths
);
    // =================================================================
    // capture, one shot after reset release
    reg [31:0] debug_reg;
    reg [31:0] power_reg;
    reg [31:0] wdog_reg;
    reg loaded_reg;
    reg [2:0] runtime_reg;
    always @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            debug_reg <= `CWD_WORD_RESET;
            power_reg <= `CWD_WORD_RESET;
            wdog_reg <= `CWD_WORD_RESET;
            loaded_reg <= 1'b0;
        end else if (!loaded_reg) begin
            // taken by the clock, never by the reset itself
            debug_reg <= i_debug_word;
            power_reg <= i_power_word;
            wdog_reg <= i_wdog_word;
            loaded_reg <= 1'b1;
        end
    end
    // =================================================================
    // runtime control register: software brown-out, retention, sleep
    wire sleep_now;
    assign sleep_now = i_sleep | runtime_reg[`CWD_RT_SLEEP_BIT];
    always @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            runtime_reg <= 3'h0;
        end else if (i_wr && i_addr == `CWD_RUNTIME_OFS) begin
            runtime_reg <= i_wdata[2:0];
        end
    end
    // =================================================================
    // field extraction
    wire [1:0] dbg_ch;
    wire [1:0] bor_pol;
    wire [1:0] run_clk;
    wire [4:0] run_ps;
    wire [4:0] slp_ps;
    wire [1:0] win_sz;
    wire [20:0] run_ratio;
    wire [20:0] slp_ratio;
    assign dbg_ch = debug_reg[`CWD_DBG_CH_HI:`CWD_DBG_CH_LO];
    assign bor_pol = power_reg[`CWD_POR_BOR_HI:`CWD_POR_BOR_LO];
    assign run_clk = wdog_reg[`CWD_WDT_CLK_HI:`CWD_WDT_CLK_LO];
    assign run_ps = wdog_reg[`CWD_WDT_RPS_HI:`CWD_WDT_RPS_LO];
    assign slp_ps = wdog_reg[`CWD_WDT_SPS_HI:`CWD_WDT_SPS_LO];
    assign win_sz = wdog_reg[`CWD_WDT_WSZ_HI:`CWD_WDT_WSZ_LO];
    cwd_postscale u_run_ps (
        .i_code(run_ps),
        .o_ratio_onehot(run_ratio)
    );
    cwd_postscale u_slp_ps (
        .i_code(slp_ps),
        .o_ratio_onehot(slp_ratio)
    );
    // =================================================================
    // decode next values
    reg bor_next;
    reg [3:0] win_next;
    always @* begin
        case (bor_pol)
            `CWD_BOR_ALWAYS: bor_next = 1'b1;
            `CWD_BOR_RUN_ONLY: bor_next = ~sleep_now;
            `CWD_BOR_SOFT: bor_next = runtime_reg[`CWD_RT_SBOR_BIT];
            default: bor_next = 1'b0;
        endcase
        case (win_sz)
            2'h3: win_next = 4'h2;
            2'h2: win_next = 4'h3;
            2'h1: win_next = 4'h4;
            default: win_next = 4'h6;
        endcase
    end
    // =================================================================
    // registered outputs; enables off, ratio 2**0, window 6 eighths until the words are in
    always @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            o_loaded <= 1'b0;
            o_debug_pin_pair_one <= 1'b0;
            o_debug_pin_pair_two <= 1'b0;
            o_debug_pin_pair_three <= 1'b0;
            o_scan_port_enable <= 1'b0;
            o_low_power_brownout_enable <= 1'b0;
            o_retention_regulator_on <= 1'b0;
            o_brownout_reset_enable <= 1'b0;
            o_watchdog_enable <= 1'b0;
            o_watchdog_clock_select <= 2'h0;
            o_watchdog_clock_reserved <= 1'b0;
            o_watchdog_ratio_onehot <= 21'h000001;
            o_window_enable <= 1'b0;
            o_window_eighths <= 4'h6;
        end else if (loaded_reg) begin
            o_loaded <= 1'b1;
            o_debug_pin_pair_one <= (dbg_ch == 2'h3);
            o_debug_pin_pair_two <= (dbg_ch == 2'h2);
            o_debug_pin_pair_three <= (dbg_ch == 2'h1);
            o_scan_port_enable <= debug_reg[`CWD_DBG_SCAN_BIT];
            // low-power detector only covers the gap left by the main one
            o_low_power_brownout_enable <= power_reg[`CWD_POR_LPBOR_BIT] & ~bor_next;
            o_retention_regulator_on <= ~power_reg[`CWD_POR_RETDIS_BIT] & sleep_now
                & runtime_reg[`CWD_RT_RETENTION_RUNTIME_ENABLE_BIT];
            o_brownout_reset_enable <= bor_next;
            o_watchdog_enable <= wdog_reg[`CWD_WDT_EN_BIT];
            o_watchdog_clock_select <= sleep_now ? `CWD_CLK_LOW_POWER_RC_OSCILLATOR : run_clk;
            o_watchdog_clock_reserved <= ~sleep_now & (run_clk == `CWD_CLK_RSVD);
            o_watchdog_ratio_onehot <= sleep_now ? slp_ratio : run_ratio;
            o_window_enable <= ~wdog_reg[`CWD_WDT_WINDOW_MODE_DISABLE_BIT];
            o_window_eighths <= win_next;
        end
    end
    // =================================================================
    // read port; unmapped reads return zero
    always @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            case (i_addr)
                `CWD_DEBUG_WORD_OFS: o_rdata <= debug_reg;
                `CWD_POWER_WORD_OFS: o_rdata <= power_reg;
                `CWD_WDOG_WORD_OFS: o_rdata <= wdog_reg;
                `CWD_STATUS_OFS: o_rdata <= {30'h0, o_brownout_reset_enable, loaded_reg};
                `CWD_RUNTIME_OFS: o_rdata <= {29'h0, runtime_reg};
                default: o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end
endmodule // cwd_decoder
`default_nettype wire

// ===== testbench/cwd_monitor.sv
// Purpose: assertions on decoded configuration outputs
// Assumes: words change only while reset is high
// Notes: bound onto cwd_decoder
`timescale 1ns/1ps
`default_nettype none
module cwd_monitor (
    input wire I_REF_CLK,
    input wire I_RST,
    input wire [31:0] i_debug_word,
    input wire [31:0] i_power_word,
    input wire [31:0] i_wdog_word,
    input wire i_sleep,
    input wire o_loaded,
    input wire o_scan_port_enable,
    input wire o_low_power_brownout_enable,
    input wire o_brownout_reset_enable,
    input wire o_watchdog_enable,
    input wire [1:0] o_watchdog_clock_select,
    input wire [3:0] o_window_eighths
);
    // =========================================
    // properties
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    wire [1:0] bp = i_power_word[1:0];
    wire [1:0] wz = i_wdog_word[6:5];
    property p_scan; o_loaded |-> o_scan_port_enable == i_debug_word[2]; endproperty
    a_scan: assert property (p_scan) else $error("scan port");
    property p_lp;
        o_loaded |-> o_low_power_brownout_enable == (i_power_word[3] && !o_brownout_reset_enable);
    endproperty
    a_lp: assert property (p_lp) else $error("low power detector");
    property p_bon; o_loaded && bp == 2'h3 |-> o_brownout_reset_enable; endproperty
    a_bon: assert property (p_bon) else $error("brownout always");
    property p_boff; o_loaded && bp == 2'h0 |-> !o_brownout_reset_enable; endproperty
    a_boff: assert property (p_boff) else $error("brownout off");
    property p_wen; o_loaded |-> o_watchdog_enable == i_wdog_word[15]; endproperty
    a_wen: assert property (p_wen) else $error("watchdog enable");
    property p_wsz;
        o_loaded |-> o_window_eighths == (wz == 2'h3 ? 4'h2 : wz == 2'h2 ? 4'h3 : wz == 2'h1 ? 4'h4 : 4'h6);
    endproperty
    a_wsz: assert property (p_wsz) else $error("window size");
    // sleep seen on two edges so the registered select has caught up
    property p_slp; o_loaded && i_sleep && $past(i_sleep) |-> o_watchdog_clock_select == 2'h3; endproperty
    a_slp: assert property (p_slp) else $error("sleep clock");
    property p_hold; o_loaded |=> o_loaded && $stable(o_scan_port_enable); endproperty
    a_hold: assert property (p_hold) else $error("outputs not held");
    c_sleep: cover property (o_loaded && i_sleep);
    c_soft: cover property (o_loaded && bp == 2'h1 && o_brownout_reset_enable);
    c_lp: cover property (o_low_power_brownout_enable);
endmodule // cwd_monitor
bind cwd_decoder cwd_monitor u_mon (.*);
`default_nettype wire

// ===== testbench/test_cwd_decoder.sv
// Purpose: random and corner checks of the configuration decoder
// Assumes: words held steady through each reset
// Notes: first four passes walk every two-bit code
`timescale 1ns/1ps
`default_nettype none
module test_cwd_decoder;
    logic I_REF_CLK = 0, I_RST = 1, i_sleep = 0, i_wr = 0, i_rd = 0;
    logic [31:0] i_debug_word = 0, i_power_word = 0, i_wdog_word = 0, i_wdata = 0, o_rdata, d, p, w;
    logic [7:0] i_addr = 0;
    logic o_loaded, o_debug_pin_pair_one, o_debug_pin_pair_two, o_debug_pin_pair_three, o_scan_port_enable;
    logic o_low_power_brownout_enable, o_retention_regulator_on, o_brownout_reset_enable, o_watchdog_enable;
    logic o_watchdog_clock_reserved, o_window_enable, slp, be;
    logic [1:0] o_watchdog_clock_select;
    logic [20:0] o_watchdog_ratio_onehot;
    logic [3:0] o_window_eighths;
    logic [3:0] ei [4] = '{4'h6, 4'h4, 4'h3, 4'h2};
    logic [31:0] seed = 32'h00001FEE;
    logic [2:0] rt;
    logic [4:0] ps;
    int n_errors = 0, tests_run = 0;
    cwd_decoder dut (.*);
    initial forever #2.5 I_REF_CLK = ~I_REF_CLK;
    // =========================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
        @(posedge I_REF_CLK);
        i_wr <= wr;
        i_rd <= !wr;
        i_addr <= a;
        i_wdata <= v;
        @(posedge I_REF_CLK);
        i_wr <= 0;
        i_rd <= 0;
        #1;
    endtask
    // =========================================
    // main sequence
    initial begin
        for (int i = 0; i < 24; i++) begin
            d = rnd() | 32'hFFFFFFE3;
            p = rnd() | 32'hFFFFFFF0;
            w = rnd() | 32'hFFFF0000;
            if (i < 4) begin
                {d[4:3], p[1:0], w[14:13], w[6:5]} = {4{i[1:0]}};
                w[4:0] = 5'h11 + i[4:0];
                w[12:8] = 5'h13 + i[4:0];
            end
            @(posedge I_REF_CLK);
            I_RST <= 1;
            {i_debug_word, i_power_word, i_wdog_word} <= {d, p, w};
            repeat (3) @(posedge I_REF_CLK);
            I_RST <= 0;
            for (int k = 0; k < 8 && o_loaded !== 1'b1; k++) @(posedge I_REF_CLK) #1;
            chk(o_loaded, 1);
            chk({o_debug_pin_pair_one, o_debug_pin_pair_two, o_debug_pin_pair_three},
                {d[4:3] == 2'h3, d[4:3] == 2'h2, d[4:3] == 2'h1});
            chk({o_window_enable, o_window_eighths}, {!w[7], ei[w[6:5]]});
            chk({o_scan_port_enable, o_watchdog_enable}, {d[2], w[15]});
            // words are read-only: a write must not disturb them
            bus(1, 8'h08, 32'h0);
            bus(0, 8'h00, 0);
            chk(o_rdata, d);
            bus(0, 8'h04, 0);
            chk(o_rdata, p);
            bus(0, 8'h08, 0);
            chk(o_rdata, w);
            bus(0, 8'h14, 0);
            chk(o_rdata, 0);
            rt = 3'(rnd());
            bus(1, 8'h10, {29'h0, rt});
            bus(0, 8'h10, 0);
            chk(o_rdata, {29'h0, rt});
            for (int s = 0; s < 2; s++) begin
                @(posedge I_REF_CLK);
                i_sleep <= s[0];
                repeat (3) @(posedge I_REF_CLK);
                #1;
                slp = s[0] | rt[2];
                be = p[1:0] == 2'h3 || (p[1:0] == 2'h2 && !slp) || (p[1:0] == 2'h1 && rt[0]);
                chk(o_brownout_reset_enable, be);
                chk(o_low_power_brownout_enable, p[3] && !be);
                chk(o_retention_regulator_on, !p[2] && slp && rt[1]);
                chk({o_watchdog_clock_select, o_watchdog_clock_reserved},
                    {slp ? 2'h3 : w[14:13], !slp && w[14:13] == 2'h1});
                ps = slp ? w[4:0] : w[12:8];
                chk(o_watchdog_ratio_onehot, 21'h1 << (ps > 5'h13 ? 5'h14 : ps));
                bus(0, 8'h0C, 0);
                chk(o_rdata, {30'h0, be, 1'b1});
            end
            $display("test %0d done", i);
        end
        stop_test();
    end
    initial begin
        #200000;
        n_errors++;
        stop_test();
    end
endmodule // test_cwd_decoder
`default_nettype wire
